/* File: rsth_host.sv */
// Purpose: Host controller that programs and watches a raster sync generator
// Assumes: Software port with one-cycle strobes, read data one cycle later
// Notes:   Parameters reach the device only after passing the width checks
//
// Functional notes
// RQ1 - Normal graphics: 16-pixel word per display cycle, two word-clock cycles.
// RQ2 - Wide access fetches even/odd word pair, 32 pixels per display cycle.
// RQ3 - Mixed graphics areas: active display cycle spans four word-clock cycles.
// RQ4 - Mixed graphics areas: active word count programmed at double value.
// RQ5 - Mixed mode retrace display cycles still last two word-clock cycles.
// RQ6 - Blanked word count equals front porch plus sync plus back porch.
// RQ7 - Vertical retrace lines blank their active part too.
// RQ8 - Line front porch at least two display cycles in general.
// RQ9 - Sync slave: line front porch at least four display cycles.
// RQ10 - Light pen: line front porch at least six display cycles.
// RQ11 - Refresh enabled: line sync at least two display cycles.
// RQ12 - Interlace: line sync at least three display cycles.
// RQ13 - Line back porch at least three display cycles always.
// RQ14 - Area or wide setting changes in field: back porch at least five.
// RQ15 - Interlace with split screen: back porch at least five.
// RQ16 - During line sync with refresh, addresses come from refresh counter.
// RQ17 - Refresh cycles have top memory arbitration priority.
// RQ18 - Line sync width at least ceil(refresh count / lines per interval).
// RQ19 - Each vertical interval at least one line; sum equals blanked lines.
// RQ20 - Line order: front porch, sync, back porch, active words.
// RQ21 - Field order: front porch, sync, back porch, active lines.
// RQ22 - Interlace adds one extra line per frame automatically.
// RQ23 - Interval counters reload at each boundary.
`default_nettype none

module rsth_host
  import rsth_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  input  wire logic        hsync_pin_in,
  input  wire logic        vsync_pin_in,
  input  wire logic        blank_pin_in,
  output logic      [7:0]  line_front_porch_out,
  output logic      [7:0]  line_sync_width_out,
  output logic      [7:0]  line_back_porch_out,
  output logic      [9:0]  active_word_count_out,
  output logic      [9:0]  blanked_word_count_out,
  output logic      [7:0]  field_front_porch_out,
  output logic      [7:0]  field_sync_lines_out,
  output logic      [7:0]  field_back_porch_out,
  output logic      [9:0]  blanked_line_count_out,
  output logic      [10:0] active_line_count_out,
  output logic             wide_access_select_out,
  output logic             mixed_mode_out,
  output logic             interlace_out,
  output logic             refresh_en_out,
  output logic             param_load_out
);

  typedef struct packed {
    logic [7:0]  flags;
    logic [7:0]  line_front_porch;
    logic [7:0]  hs;
    logic [7:0]  line_back_porch;
    logic [8:0]  aw;
    logic [7:0]  field_front_porch;
    logic [7:0]  vs;
    logic [7:0]  field_back_porch;
    logic [10:0] al;
    logic [7:0]  rcc;
    logic [15:0] lri;
    logic        apply_pend;
    logic [5:0]  err;
    logic        loaded;
    logic        fault;
    logic [7:0]  o_flags;
    logic [7:0]  o_hfp;
    logic [7:0]  o_hs;
    logic [7:0]  o_hbp;
    logic [9:0]  o_aw;
    logic [9:0]  o_bw;
    logic [7:0]  o_vfp;
    logic [7:0]  o_vs;
    logic [7:0]  o_vbp;
    logic [9:0]  o_bl;
    logic [10:0] o_al;
    logic [15:0] o_lri;
    logic        load;
    logic [31:0] rdata;
    logic [2:0]  pin_prev;
    logic [15:0] line_cnt;
    logic [15:0] last_lines;
    logic [15:0] hs_cnt;
    logic [15:0] hs_width;
  } rsth_state_t;

  rsth_state_t st_reg;
  rsth_state_t st_next;
  logic [2:0]  pin_async;
  logic [2:0]  pin_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Least widths that the chosen operating options call for
  function automatic logic [7:0] rsth_hfp_min(input logic [7:0] f);
    if (f[RSTH_FLAG_PEN]) begin
      return RSTH_HFP_MIN_PEN; // RQ10
    end else if (f[RSTH_FLAG_SLAVE]) begin
      return RSTH_HFP_MIN_SLAVE; // RQ9
    end
    return RSTH_HFP_MIN_GEN; // RQ8
  endfunction

  function automatic logic [7:0] rsth_hs_min(input logic [7:0] f);
    if (f[RSTH_FLAG_ILACE]) begin
      return RSTH_HS_MIN_ILACE; // RQ12
    end else if (f[RSTH_FLAG_REFRESH]) begin
      return RSTH_HS_MIN_REF; // RQ11
    end
    return RSTH_HS_MIN_GEN;
  endfunction

  function automatic logic [7:0] rsth_hbp_min(input logic [7:0] f);
    if (f[RSTH_FLAG_CHANGE]) begin
      return RSTH_HBP_MIN_EXT; // RQ14
    end else if (f[RSTH_FLAG_ILACE] && f[RSTH_FLAG_SPLIT]) begin
      return RSTH_HBP_MIN_EXT; // RQ15
    end
    return RSTH_HBP_MIN_GEN; // RQ13
  endfunction

  // Refresh slots per line must cover the refresh count over one interval
  function automatic logic rsth_refresh_ok(input logic [7:0] hs, input logic [15:0] lri,
                                           input logic [7:0] rcc);
    logic [23:0] prod;
    prod = 24'(hs) * 24'(lri);
    return (lri != 16'h0000) && (prod >= 24'(rcc)); // RQ18
  endfunction

  function automatic logic [9:0] rsth_sum3(input logic [7:0] a, input logic [7:0] b,
                                           input logic [7:0] c);
    return {2'b00, a} + {2'b00, b} + {2'b00, c};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Device pins pass two flip-flops before any logic looks at them
  assign pin_async = {blank_pin_in, vsync_pin_in, hsync_pin_in};

  for (genvar gi = 0; gi < 3; gi++) begin : g_pin_sync
    rsth_sync2 u_sync (
      .mclk_in  (mclk_in),
      .rst_b_in (rst_b_in),
      .async_in (pin_async[gi]),
      .sync_out (pin_sync[gi])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic: register port, checks, parameter load, pin monitor
  always_comb begin
    logic [5:0] chk;
    logic       hs_rise;
    logic       hs_fall;
    logic       vs_rise;
    chk     = 6'h00;
    hs_rise = pin_sync[0] & ~st_reg.pin_prev[0];
    hs_fall = ~pin_sync[0] & st_reg.pin_prev[0];
    vs_rise = pin_sync[1] & ~st_reg.pin_prev[1];
    st_next = st_reg;
    st_next.load = 1'b0;
    st_next.pin_prev = pin_sync;

    // Parameter checks against the stored programming
    if (st_reg.line_front_porch < rsth_hfp_min(st_reg.flags)) begin
      chk[RSTH_ERR_HFP] = 1'b1; // RQ8
    end
    if (st_reg.hs < rsth_hs_min(st_reg.flags)) begin
      chk[RSTH_ERR_HS] = 1'b1; // RQ11
    end
    if (st_reg.line_back_porch < rsth_hbp_min(st_reg.flags)) begin
      chk[RSTH_ERR_HBP] = 1'b1; // RQ13
    end
    if (st_reg.flags[RSTH_FLAG_REFRESH] && !rsth_refresh_ok(st_reg.hs, st_reg.lri, st_reg.rcc))
    begin
      chk[RSTH_ERR_REFRESH] = 1'b1; // RQ18
    end
    if ((st_reg.field_front_porch < RSTH_VINT_MIN) || (st_reg.vs < RSTH_VINT_MIN) ||
        (st_reg.field_back_porch < RSTH_VINT_MIN)) begin
      chk[RSTH_ERR_VERT] = 1'b1; // RQ19
    end
    if ((st_reg.aw == 9'h000) || (st_reg.al == 11'h000)) begin
      chk[RSTH_ERR_ZERO] = 1'b1;
    end

    // Status clear first so that a hardware set in the same cycle wins
    if (wr_in && (addr_in == RSTH_ADDR_STATUS)) begin
      st_next.err = st_reg.err & ~wdata_in[5:0];
      if (wdata_in[RSTH_ST_FAULT]) begin
        st_next.fault = 1'b0;
      end
      if (wdata_in[RSTH_ST_LOADED]) begin
        st_next.loaded = 1'b0;
      end
    end

    // One cycle after apply the checked set is loaded or refused
    if (st_reg.apply_pend) begin
      st_next.apply_pend = 1'b0;
      st_next.err = st_next.err | chk;
      if (chk == 6'h00) begin
        st_next.load    = 1'b1;
        st_next.loaded  = 1'b1;
        st_next.o_flags = st_reg.flags;
        st_next.o_hfp   = st_reg.line_front_porch;
        st_next.o_hs    = st_reg.hs;
        st_next.o_hbp   = st_reg.line_back_porch;
        st_next.o_bw    = rsth_sum3(st_reg.line_front_porch, st_reg.hs, st_reg.line_back_porch); // RQ6
        st_next.o_aw    = st_reg.flags[RSTH_FLAG_MIXED] ? {st_reg.aw, 1'b0}
                                                        : {1'b0, st_reg.aw}; // RQ4
        st_next.o_vfp   = st_reg.field_front_porch;
        st_next.o_vs    = st_reg.vs;
        st_next.o_vbp   = st_reg.field_back_porch;
        st_next.o_bl    = rsth_sum3(st_reg.field_front_porch, st_reg.vs, st_reg.field_back_porch); // RQ19
        st_next.o_al    = st_reg.al;
        st_next.o_lri   = st_reg.lri;
      end
    end

    // Software writes; a write to control with apply queues a check
    if (wr_in) begin
      unique case (addr_in)
        RSTH_ADDR_CTRL: begin
          st_next.flags      = wdata_in[RSTH_CTRL_FLAG_LO +: 8];
          st_next.apply_pend = wdata_in[RSTH_CTRL_APPLY];
        end
        RSTH_ADDR_HTIME: begin
          st_next.line_front_porch = wdata_in[7:0];
          st_next.hs  = wdata_in[15:8];
          st_next.line_back_porch = wdata_in[23:16];
        end
        RSTH_ADDR_AWORDS: st_next.aw = wdata_in[8:0];
        RSTH_ADDR_VTIME: begin
          st_next.field_front_porch = wdata_in[7:0];
          st_next.vs  = wdata_in[15:8];
          st_next.field_back_porch = wdata_in[23:16];
        end
        RSTH_ADDR_ALINES: st_next.al = wdata_in[10:0];
        RSTH_ADDR_REFRESH: begin
          st_next.rcc = wdata_in[7:0];
          st_next.lri = wdata_in[23:8];
        end
        default: ;
      endcase
    end

    // Read data stands only in the cycle after the strobe
    st_next.rdata = 32'h0000_0000;
    if (rd_in) begin
      unique case (addr_in)
        RSTH_ADDR_CTRL:    st_next.rdata = {23'h0, st_reg.flags, st_reg.apply_pend};
        RSTH_ADDR_HTIME:   st_next.rdata = {8'h00, st_reg.line_back_porch, st_reg.hs, st_reg.line_front_porch};
        RSTH_ADDR_AWORDS:  st_next.rdata = {23'h0, st_reg.aw};
        RSTH_ADDR_VTIME:   st_next.rdata = {8'h00, st_reg.field_back_porch, st_reg.vs, st_reg.field_front_porch};
        RSTH_ADDR_ALINES:  st_next.rdata = {21'h0, st_reg.al};
        RSTH_ADDR_REFRESH: st_next.rdata = {8'h00, st_reg.lri, st_reg.rcc};
        RSTH_ADDR_STATUS:  st_next.rdata = {23'h0, st_reg.loaded, 1'b0, st_reg.fault,
                                            st_reg.err};
        RSTH_ADDR_MON:     st_next.rdata = {st_reg.hs_width, st_reg.last_lines};
        default:           st_next.rdata = 32'h0000_0000;
      endcase
    end

    // Lines per field, counted on line sync edges between field sync edges
    if (vs_rise) begin
      st_next.last_lines = st_reg.line_cnt + 16'(hs_rise);
      st_next.line_cnt   = 16'h0000;
    end else if (hs_rise && (st_reg.line_cnt != RSTH_CNT_MAX)) begin
      st_next.line_cnt = st_reg.line_cnt + 16'h0001;
    end

    // Line sync width in mclk cycles, saturating for a stuck pin
    if (hs_fall) begin
      st_next.hs_width = st_reg.hs_cnt;
      st_next.hs_cnt   = 16'h0000;
    end else if (pin_sync[0] && (st_reg.hs_cnt != RSTH_CNT_MAX)) begin
      st_next.hs_cnt = st_reg.hs_cnt + 16'h0001;
    end

    // Video unblanked while field sync is high is a device fault
    if (pin_sync[1] && !pin_sync[2]) begin
      st_next.fault = 1'b1; // RQ7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; everything resets to constants
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_reg         <= '0;
      st_reg.flags   <= RSTH_RST_FLAGS;
      st_reg.o_flags <= RSTH_RST_FLAGS;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign rdata_out              = st_reg.rdata;
  assign line_front_porch_out   = st_reg.o_hfp;
  assign line_sync_width_out    = st_reg.o_hs;
  assign line_back_porch_out    = st_reg.o_hbp;
  assign active_word_count_out  = st_reg.o_aw;
  assign blanked_word_count_out = st_reg.o_bw;
  assign field_front_porch_out  = st_reg.o_vfp;
  assign field_sync_lines_out   = st_reg.o_vs;
  assign field_back_porch_out   = st_reg.o_vbp;
  assign blanked_line_count_out = st_reg.o_bl;
  assign active_line_count_out  = st_reg.o_al;
  assign wide_access_select_out = st_reg.o_flags[RSTH_FLAG_WIDE];
  assign mixed_mode_out         = st_reg.o_flags[RSTH_FLAG_MIXED];
  assign interlace_out          = st_reg.o_flags[RSTH_FLAG_ILACE];
  assign refresh_en_out         = st_reg.o_flags[RSTH_FLAG_REFRESH];
  assign param_load_out         = st_reg.load;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on what reaches the device
  AST_HFP_MIN: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // RQ8
    param_load_out |-> line_front_porch_out >= (st_reg.o_flags[RSTH_FLAG_PEN] ? 8'h06 :
      st_reg.o_flags[RSTH_FLAG_SLAVE] ? 8'h04 : 8'h02))
    else $error("Front porch below least width at load");

  AST_HS_MIN: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // RQ12
    param_load_out && interlace_out |-> line_sync_width_out >= 8'h03)
    else $error("Sync width too short for interlace");

  AST_HS_REF: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // RQ11
    param_load_out && refresh_en_out |-> line_sync_width_out >= 8'h02)
    else $error("Sync width too short for refresh");

  AST_HBP_MIN: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // RQ14
    param_load_out && st_reg.o_flags[RSTH_FLAG_CHANGE] |-> line_back_porch_out >= 8'h05)
    else $error("Back porch too short for mid-field mode change");

  AST_HBP_GEN: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // RQ13
    param_load_out |-> line_back_porch_out >= 8'h03)
    else $error("Back porch below three display cycles");

  AST_REFRESH: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // RQ18
    param_load_out && refresh_en_out |->
      (24'(line_sync_width_out) * 24'(st_reg.o_lri)) >= 24'(st_reg.rcc))
    else $error("Sync width gives too few refresh slots");

  AST_VERT: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // RQ19
    param_load_out |-> (field_front_porch_out != 8'h00) && (field_sync_lines_out != 8'h00)
      && (field_back_porch_out != 8'h00) && (blanked_line_count_out ==
      {2'b00, field_front_porch_out} + {2'b00, field_sync_lines_out} +
      {2'b00, field_back_porch_out}))
    else $error("Vertical intervals illegal at load");

  AST_BW_SUM: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // RQ6
    param_load_out |-> blanked_word_count_out == {2'b00, line_front_porch_out} +
      {2'b00, line_sync_width_out} + {2'b00, line_back_porch_out})
    else $error("Blanked word count not the sum of porches and sync");

  AST_AW_MIXED: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // RQ4
    st_reg.apply_pend && st_reg.flags[RSTH_FLAG_MIXED] ##1 param_load_out |->
      active_word_count_out == {$past(st_reg.aw), 1'b0})
    else $error("Mixed mode active words not doubled");

  AST_REFUSE: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // RQ13
    st_reg.apply_pend && (st_reg.line_back_porch < 8'h03) |=> !param_load_out && st_reg.err[2])
    else $error("Short back porch was not refused");

endmodule // rsth_host

`default_nettype wire

/* File: rsth_pkg.sv */
// Purpose: Shared constants for the raster sync timing host controller
// Assumes: Word-addressed software port, 4-bit address, 32-bit data
// Notes:   Interval widths are in display cycles, vertical ones in lines
`default_nettype none

package rsth_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Software register word addresses
  localparam logic [3:0] RSTH_ADDR_CTRL    = 4'h0;
  localparam logic [3:0] RSTH_ADDR_HTIME   = 4'h1;
  localparam logic [3:0] RSTH_ADDR_AWORDS  = 4'h2;
  localparam logic [3:0] RSTH_ADDR_VTIME   = 4'h3;
  localparam logic [3:0] RSTH_ADDR_ALINES  = 4'h4;
  localparam logic [3:0] RSTH_ADDR_REFRESH = 4'h5;
  localparam logic [3:0] RSTH_ADDR_STATUS  = 4'h6;
  localparam logic [3:0] RSTH_ADDR_MON     = 4'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Control register bit positions (bit 0 is the apply command)
  localparam int RSTH_CTRL_APPLY   = 0;
  localparam int RSTH_CTRL_FLAG_LO = 1;
  localparam int RSTH_FLAG_SLAVE   = 0;
  localparam int RSTH_FLAG_PEN     = 1;
  localparam int RSTH_FLAG_REFRESH = 2;
  localparam int RSTH_FLAG_ILACE   = 3;
  localparam int RSTH_FLAG_CHANGE  = 4;
  localparam int RSTH_FLAG_SPLIT   = 5;
  localparam int RSTH_FLAG_MIXED   = 6;
  localparam int RSTH_FLAG_WIDE    = 7;

  ////////////////////////////////////////////////////////////////////////////
  // Status register bit positions
  localparam int RSTH_ERR_HFP     = 0;
  localparam int RSTH_ERR_HS      = 1;
  localparam int RSTH_ERR_HBP     = 2;
  localparam int RSTH_ERR_REFRESH = 3;
  localparam int RSTH_ERR_VERT    = 4;
  localparam int RSTH_ERR_ZERO    = 5;
  localparam int RSTH_ST_FAULT    = 6;
  localparam int RSTH_ST_LOADED   = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Least interval widths in display cycles, vertical ones in lines
  localparam logic [7:0] RSTH_HFP_MIN_GEN   = 8'h02;
  localparam logic [7:0] RSTH_HFP_MIN_SLAVE = 8'h04;
  localparam logic [7:0] RSTH_HFP_MIN_PEN   = 8'h06;
  localparam logic [7:0] RSTH_HS_MIN_GEN    = 8'h01;
  localparam logic [7:0] RSTH_HS_MIN_REF    = 8'h02;
  localparam logic [7:0] RSTH_HS_MIN_ILACE  = 8'h03;
  localparam logic [7:0] RSTH_HBP_MIN_GEN   = 8'h03;
  localparam logic [7:0] RSTH_HBP_MIN_EXT   = 8'h05;
  localparam logic [7:0] RSTH_VINT_MIN      = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and monitor limits
  localparam logic [7:0]  RSTH_RST_FLAGS = 8'h00;
  localparam logic [15:0] RSTH_CNT_MAX   = 16'hFFFF;

endpackage : rsth_pkg

`default_nettype wire

/* File: rsth_sync2.sv */
// Purpose: Two-flip-flop synchroniser for pins from the display device
// Assumes: Pins are levels, asynchronous to mclk_in
// Notes:   First stage feeds only the second stage
`default_nettype none

module rsth_sync2 (
  input  wire logic mclk_in,
  input  wire logic rst_b_in,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Two stages, reset low so outputs are defined from reset onward
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // rsth_sync2

`default_nettype wire

/* File: rsth_crt_dev.sv */
// Purpose: Behavioural raster sync device driving the host's pin inputs
// Assumes: One mclk_in cycle stands for one word-clock cycle
// Notes:   Counters restart on every load; pins idle blanked until then
`default_nettype none
module rsth_crt_dev (
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  input  wire logic        load_in,
  input  wire logic [7:0]  line_front_porch_in,
  input  wire logic [7:0]  line_sync_width_in,
  input  wire logic [7:0]  line_back_porch_in,
  input  wire logic [9:0]  active_word_count_in,
  input  wire logic [7:0]  field_front_porch_in,
  input  wire logic [7:0]  field_sync_lines_in,
  input  wire logic [7:0]  field_back_porch_in,
  input  wire logic [10:0] active_line_count_in,
  input  wire logic        mixed_mode_in,
  input  wire logic        interlace_in,
  output logic             hsync_out,
  output logic             vsync_out,
  output logic             blank_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0]  hst_reg, vst_reg, sub_reg;
  logic [10:0] hcnt_reg, vcnt_reg, hlen, vlen;
  logic        run_reg, odd_reg;
  ////////////////////////////////////////////////////////////////////////////
  // Length of the current interval; blanked part is porch + sync + porch
  always_comb begin
    case (hst_reg)
      2'h0: hlen = 11'(line_front_porch_in);
      2'h1: hlen = 11'(line_sync_width_in);
      2'h2: hlen = 11'(line_back_porch_in);
      default: hlen = 11'(active_word_count_in);
    endcase
    case (vst_reg)
      2'h0: vlen = 11'(field_front_porch_in);
      2'h1: vlen = 11'(field_sync_lines_in);
      2'h2: vlen = 11'(field_back_porch_in);
      default: vlen = active_line_count_in + 11'(interlace_in & odd_reg);
    endcase
  end
  // Two word clocks per display cycle, four for active words in mixed mode
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      run_reg <= 1'b0;
      {hst_reg, vst_reg, sub_reg, hcnt_reg, vcnt_reg, odd_reg} <= '0;
    end else if (load_in) begin
      run_reg <= 1'b1;
      {hst_reg, vst_reg, sub_reg, hcnt_reg, vcnt_reg, odd_reg} <= '0;
    end else if (run_reg) begin
      sub_reg <= sub_reg + 2'h1;
      if (sub_reg == ((mixed_mode_in && hst_reg == 2'h3) ? 2'h3 : 2'h1)) begin
        sub_reg  <= 2'h0;
        hcnt_reg <= hcnt_reg + 11'h1;
        if (hcnt_reg + 11'h1 >= hlen) begin
          hcnt_reg <= 11'h0;
          hst_reg  <= hst_reg + 2'h1;
          if (hst_reg == 2'h3) begin
            vcnt_reg <= vcnt_reg + 11'h1;
            if (vcnt_reg + 11'h1 >= vlen) begin
              vcnt_reg <= 11'h0;
              vst_reg  <= vst_reg + 2'h1;
              odd_reg  <= odd_reg ^ (vst_reg == 2'h3);
            end
          end
        end
      end
    end
  end
  // Whole lines stay blanked outside active lines, not only the retrace
  assign hsync_out = run_reg && hst_reg == 2'h1;
  assign vsync_out = run_reg && vst_reg == 2'h1;
  assign blank_out = !run_reg || hst_reg != 2'h3 || vst_reg != 2'h3;
endmodule // rsth_crt_dev
`default_nettype wire

/* File: tb_rsth_host.sv */
// Purpose: Self-checking bench for the raster sync host controller
// Assumes: Device model drives the sync pins from the loaded parameters
// Notes:   Expected values follow the interval minimums, not the design
`default_nettype none
module tb_rsth_host import rsth_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk_in, rst_b_in, wr_in, rd_in, hsync, vsync, blank, param_load_out;
  logic        wide_access_select_out, mixed_mode_out, interlace_out, refresh_en_out;
  logic [3:0]  addr_in;
  logic [31:0] wdata_in, rdata_out, d;
  logic [7:0]  line_front_porch_out, line_sync_width_out, line_back_porch_out;
  logic [7:0]  field_front_porch_out, field_sync_lines_out, field_back_porch_out;
  logic [9:0]  active_word_count_out, blanked_word_count_out, blanked_line_count_out;
  logic [10:0] active_line_count_out;
  int          err_total, checked;
  // Line timing word, control flags and expected error bits per case
  localparam logic [31:0] HT_TBL [16] = '{32'h30101, 32'h30102, 32'h30103, 32'h30104,
    32'h30105, 32'h30106, 32'h30102, 32'h30202, 32'h30302, 32'h30202, 32'h30302,
    32'h20102, 32'h40102, 32'h50102, 32'h40302, 32'h50302};
  localparam logic [7:0] FL_TBL [16] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h03, 8'h03,
    8'h04, 8'h04, 8'h04, 8'h08, 8'h08, 8'h00, 8'h10, 8'h10, 8'h28, 8'h28};
  localparam logic [31:0] EX_TBL [16] = '{32'h1, 32'h0, 32'h1, 32'h0, 32'h1, 32'h0,
    32'hA, 32'h8, 32'h0, 32'h2, 32'h0, 32'h4, 32'h4, 32'h0, 32'h4, 32'h0};
  ////////////////////////////////////////////////////////////////////////////
  rsth_host u_rsth_host (.mclk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .hsync_pin_in(hsync), .vsync_pin_in(vsync), .blank_pin_in(blank),
    .line_front_porch_out, .line_sync_width_out, .line_back_porch_out,
    .active_word_count_out, .blanked_word_count_out, .field_front_porch_out,
    .field_sync_lines_out, .field_back_porch_out, .blanked_line_count_out,
    .active_line_count_out, .wide_access_select_out, .mixed_mode_out, .interlace_out,
    .refresh_en_out, .param_load_out);
  rsth_crt_dev u_rsth_crt_dev (.mclk_in, .rst_b_in, .load_in(param_load_out),
    .line_front_porch_in(line_front_porch_out), .line_sync_width_in(line_sync_width_out),
    .line_back_porch_in(line_back_porch_out), .active_word_count_in(active_word_count_out),
    .field_front_porch_in(field_front_porch_out), .field_sync_lines_in(field_sync_lines_out),
    .field_back_porch_in(field_back_porch_out), .active_line_count_in(active_line_count_out),
    .mixed_mode_in(mixed_mode_out), .interlace_in(interlace_out),
    .hsync_out(hsync), .vsync_out(vsync), .blank_out(blank));
  ////////////////////////////////////////////////////////////////////////////
  always #2 mclk_in = ~mclk_in;
  // Compare one value; case inequality so unknowns never pass
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobes are raised after an edge and dropped after the sampling edge
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= v;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  // Apply flags; the load pulse stands one edge after the write edge
  task automatic apply(input logic [7:0] fl, input logic exp_load);
    wr(RSTH_ADDR_CTRL, {23'h0, fl, 1'b1});
    @(posedge mclk_in);
    #1 chk(32'(param_load_out), 32'(exp_load));
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Watchdog: the sequence needs a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge mclk_in);
    err_total++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk_in = 1'b0;
    rst_b_in = 1'b0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 4'h0;
    wdata_in = 32'h0;
    repeat (12) @(posedge mclk_in);
    #1 chk({line_front_porch_out, line_sync_width_out, line_back_porch_out, 7'h0,
            param_load_out}, 32'h0);
    rst_b_in <= 1'b1;
    rd(RSTH_ADDR_STATUS, d);
    chk(d, 32'h0);
    // Smallest legal line and field, then check the derived sums
    wr(RSTH_ADDR_HTIME, 32'h30102);
    wr(RSTH_ADDR_AWORDS, 32'h4);
    wr(RSTH_ADDR_VTIME, 32'h10101);
    wr(RSTH_ADDR_ALINES, 32'h5);
    wr(RSTH_ADDR_REFRESH, 32'h206);
    apply(8'h00, 1'b1);
    chk({line_front_porch_out, line_sync_width_out, line_back_porch_out, 8'h0},
        32'h02010300);
    chk(32'(blanked_word_count_out), 32'h6);
    chk(32'(blanked_line_count_out), 32'h3);
    chk(32'(active_line_count_out), 32'h5);
    chk({8'h0, field_back_porch_out, field_sync_lines_out, field_front_porch_out},
        32'h10101);
    @(posedge mclk_in);
    #1 chk(32'(param_load_out), 32'h0);
    // Mixed areas double the word count; wide access passes through
    apply(8'hC0, 1'b1);
    chk(32'(active_word_count_out), 32'h8);
    chk({30'h0, mixed_mode_out, wide_access_select_out}, 32'h3);
    // Each minimum but the general sync one just below and at its bound, under each flag that raises one
    for (int i = 0; i < 16; i++) begin
      wr(RSTH_ADDR_STATUS, 32'hFFFFFFFF);
      wr(RSTH_ADDR_HTIME, HT_TBL[i]);
      apply(FL_TBL[i], EX_TBL[i] == 32'h0);
      rd(RSTH_ADDR_STATUS, d);
      chk(d & 32'h3F, EX_TBL[i]);
    end
    chk({29'h0, interlace_out, refresh_en_out, 1'b0}, 32'h4);
    // A zero-line vertical interval is refused and outputs hold
    wr(RSTH_ADDR_STATUS, 32'hFFFFFFFF);
    wr(RSTH_ADDR_VTIME, 32'h10001);
    apply(8'h00, 1'b0);
    rd(RSTH_ADDR_STATUS, d);
    chk(d & 32'h3F, 32'h10);
    chk(32'(line_back_porch_out), 32'h5);
    // Final legal load, let the device scan a few fields, then watch it
    wr(RSTH_ADDR_VTIME, 32'h10101);
    wr(RSTH_ADDR_HTIME, 32'h30102);
    wr(RSTH_ADDR_STATUS, 32'hFFFFFFFF);
    apply(8'h00, 1'b1);
    repeat (600) @(posedge mclk_in);
    rd(RSTH_ADDR_MON, d);
    chk(d, 32'h00020008);
    rd(RSTH_ADDR_STATUS, d);
    chk(d, 32'h100);
    @(posedge mclk_in);
    #1 chk(rdata_out, 32'h0);
    rd(4'h9, d);
    chk(d, 32'h0);
    tally_and_finish();
  end
endmodule // tb_rsth_host
`default_nettype wire
